// >>> bench/stream_receiver.sv
`timescale 1ns/100ps
`default_nettype none

module stream_receiver (
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic bit_in,
  input  wire logic clear_in,
  output var  logic mod_clk_out,
  output var  int   ones,
  output var  int   bits,
  output var  int   max_run
);
  logic [2:0] div_ff;
  logic       last_ff;
  int         run_ff;
  int         nxt_run;

  ////////////////////////////////////////////////////////////////////////
  // free-running clock, 8 system cycles each half: keeps the 4-cycle minimum
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      div_ff      <= 3'h0;
      mod_clk_out <= 1'b0;
    end else begin
      div_ff <= div_ff + 3'h1;
      if (div_ff == 3'h7) mod_clk_out <= ~mod_clk_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // box average stands in for the decimator; the previous bit stands at our rise
  always_comb nxt_run = (bit_in === last_ff) ? run_ff + 1 : 1;
  always_ff @(posedge clock_in) begin
    if (clear_in) begin
      ones    <= 0;
      bits    <= 0;
      max_run <= 0;
      run_ff  <= 0;
    end else if (div_ff == 3'h7 && !mod_clk_out) begin
      bits    <= bits + 1;
      ones    <= ones + int'(bit_in);
      run_ff  <= nxt_run;
      last_ff <= bit_in;
      if (nxt_run > max_run) max_run <= nxt_run;
    end
  end
endmodule : stream_receiver

`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import bitstream_out_pkg::*;
  logic               clock_in, rst_in, clear, mclk, dout, coded, valid, chop, carrier;
  supply_status_t     supply;
  logic signed [17:0] level;
  int                 ones, bits, max_run, error_cnt, compares;

  isolated_modulator_bitstream_out uut (.clock_in(clock_in), .rst_in(rst_in),
    .modulator_clock_in(mclk), .supply_in(supply), .input_level_uv_in(level),
    .bitstream_out(dout), .bitstream_valid_out(valid), .chopper_phase_out(chop),
    .carrier_on_out(carrier));
  isolated_modulator_bitstream_out #(.MANCHESTER(1'b1)) uut_coded (.clock_in(clock_in),
    .rst_in(rst_in), .modulator_clock_in(mclk), .supply_in(supply),
    .input_level_uv_in(level), .bitstream_out(coded), .bitstream_valid_out(),
    .chopper_phase_out(), .carrier_on_out());
  stream_receiver rx (.clock_in(clock_in), .rst_in(rst_in), .bit_in(dout), .clear_in(clear),
    .mod_clk_out(mclk), .ones(ones), .bits(bits), .max_run(max_run));

  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : check

  task automatic rises(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : rises

  // settle, then count ones over 256 bits; the tolerance covers loop start-up
  task automatic measure(input int lvl, input int exp_ones, input int tol, input int run);
    level = 18'(lvl);
    rises(8);
    clear = 1'b1;
    @(posedge clock_in);
    #1 clear = 1'b0;
    rises(256);
    check(ones >= exp_ones - tol && ones <= exp_ones + tol, "ones density");
    if (run > 0) check(max_run === run, "marker spacing");
    repeat (6) @(posedge clock_in);
    #1 check(carrier === dout && coded === ~dout, "carrier or coded high half");
    repeat (8) @(posedge clock_in);
    #1 check(coded === dout, "coded low half");
  endtask : measure

  task automatic startup_test;
    rises(40);
    check(valid === 1'b0 && dout === 1'b0, "output before supplies");
    supply = '{1'b1, 1'b1, 1'b0};
    rises(31);
    check(valid === 1'b0, "valid too early");
    rises(2);
    check(valid === 1'b1, "valid late");
  endtask : startup_test

  task automatic chopper_test;
    int flips;
    logic prev;
    flips = 0;
    prev  = chop;
    repeat (64) begin
      rises(1);
      if (chop !== prev) flips++;
      prev = chop;
    end
    check(flips == 4, "chopper rate");
  endtask : chopper_test

  task automatic failsafe_test;
    supply = '{1'b0, 1'b1, 1'b0};
    measure(0, 0, 0, 256);
    supply = '{1'b1, 1'b1, 1'b1};
    measure(0, 256, 0, 256);
    supply = '{1'b1, 1'b1, 1'b0};
  endtask : failsafe_test

  task automatic end_of_test;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test

  initial begin
    error_cnt = 0;
    compares  = 0;
    rst_in    = 1'b1;
    clear     = 1'b1;
    level     = 18'sh0;
    supply    = '{1'b0, 1'b0, 1'b0};
    repeat (8) @(posedge clock_in);
    #1 rst_in = 1'b0;
    startup_test();
    chopper_test();
    measure(0, 128, 4, 0);
    measure(50000, 228, 4, 0);
    measure(-50000, 28, 4, 0);
    measure(32000, 192, 4, 0);
    measure(64000, 254, 0, 127);
    measure(-64000, 2, 0, 127);
    measure(70000, 254, 0, 127);
    failsafe_test();
    end_of_test();
  end

  // the run needs about 40k cycles; 100k cycles is the ceiling
  initial begin
    #400000;
    error_cnt++;
    end_of_test();
  end
endmodule : testbench

`default_nettype wire

// >>> logic/bitstream_out_params.svh
`ifndef BITSTREAM_OUT_PARAMS_SVH
`define BITSTREAM_OUT_PARAMS_SVH

// input level is a signed count of microvolts
`define CLIP_LEVEL_UV      24'sd64000
// modulator clock periods from supplies good to valid output
`define STARTUP_PERIODS    6'd32
// one marker bit per this many bits at full scale
`define MARKER_PERIOD      8'd128
// chopper switches at modulator clock divided by this
`define CHOP_DIVIDE        6'd32

`endif

// >>> logic/bitstream_out_pkg.sv
`default_nettype none

package bitstream_out_pkg;

  typedef enum logic [2:0] {
    MODE_WAIT_SUPPLY = 3'b001,
    MODE_STARTUP     = 3'b010,
    MODE_RUN         = 3'b100
  } out_mode_t;

  typedef struct packed {
    out_mode_t          mode;
    logic               clk_prev;
    logic [5:0]         start_cnt;
    logic [4:0]         chop_cnt;
    logic               chop;
    logic signed [23:0] integ1;
    logic signed [23:0] integ2;
    logic               dac_level;
    logic [6:0]         mark_cnt;
    logic               tx_bit;
    logic               carrier;
    logic               rx_bit;
    logic               valid;
    logic               dout;
  } out_state_t;

  typedef struct packed {
    logic high_side_supply_ok;
    logic controller_side_supply_ok;
    logic common_mode_overvoltage;
  } supply_status_t;

endpackage : bitstream_out_pkg

`default_nettype wire

// >>> logic/isolated_modulator_bitstream_out.sv
`timescale 1ns/100ps
`default_nettype none
`include "bitstream_out_params.svh"

module isolated_modulator_bitstream_out #(
  parameter bit MANCHESTER = 1'b0
) (
  input  wire logic                            clock_in,
  input  wire logic                            rst_in,
  input  wire logic                            modulator_clock_in,
  input  wire bitstream_out_pkg::supply_status_t supply_in,
  input  wire logic signed [17:0]              input_level_uv_in,
  output var  logic                            bitstream_out,
  output var  logic                            bitstream_valid_out,
  output var  logic                            chopper_phase_out,
  output var  logic                            carrier_on_out
);
  import bitstream_out_pkg::*;

  out_state_t         st_ff;
  out_state_t         nxt_st;
  logic               clk_rise;
  logic               neg_clip;
  logic               pos_clip;
  logic               decision;
  logic signed [23:0] x_in;
  logic signed [23:0] dac_val;
  logic signed [23:0] sum1;
  logic signed [23:0] sum2;
  logic               loop_bit;
  logic               clip_on;

  ////////////////////////////////////////////////////////////////////////////
  // bit source helpers

  // failsafe wins over clipping, so a dead high side never passes for a
  // full scale input
  function automatic logic loop_owns_bit(input supply_status_t s,
                                         input logic           lo_clip,
                                         input logic           hi_clip);
    loop_owns_bit = s.high_side_supply_ok && !s.common_mode_overvoltage
      && !lo_clip && !hi_clip;
  endfunction : loop_owns_bit

  // the clipped stream carries one inverted bit per marker period
  function automatic logic clip_bit(input logic [6:0] cnt,
                                    input logic       hi_clip);
    clip_bit = (cnt == 7'(`MARKER_PERIOD - 8'd1)) ^ hi_clip;
  endfunction : clip_bit

  // a clip level owns the bit unless a failsafe source does
  function automatic logic clip_owns_bit(input supply_status_t s,
                                         input logic           lo_clip,
                                         input logic           hi_clip);
    clip_owns_bit = s.high_side_supply_ok && !s.common_mode_overvoltage
      && (lo_clip || hi_clip);
  endfunction : clip_owns_bit

  ////////////////////////////////////////////////////////////////////////////
  // modulator arithmetic

  assign clk_rise = modulator_clock_in & ~st_ff.clk_prev;
  assign x_in     = 24'(input_level_uv_in);
  assign neg_clip = (x_in <= -`CLIP_LEVEL_UV);
  assign pos_clip = (x_in >= `CLIP_LEVEL_UV);
  // one bit feedback swings between the clipping levels, which sets density
  assign dac_val  = st_ff.dac_level ? `CLIP_LEVEL_UV : -`CLIP_LEVEL_UV;
  assign sum1     = st_ff.integ1 + x_in - dac_val;
  assign sum2     = st_ff.integ2 + sum1 - dac_val;
  // feed-forward of the input into the comparator, second order loop
  assign decision = ((sum2 + x_in) >= 24'sd0);
  // who owns the next bit, used by the checks; the update decodes the same inputs itself
  assign loop_bit = loop_owns_bit(supply_in, neg_clip, pos_clip);
  assign clip_on  = clip_owns_bit(supply_in, neg_clip, pos_clip);

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    nxt_st          = st_ff;
    nxt_st.clk_prev = modulator_clock_in;
    // barrier: a one keys the carrier, the receiver recovers it a cycle later
    nxt_st.carrier  = st_ff.tx_bit;
    nxt_st.rx_bit   = st_ff.carrier;

    case (st_ff.mode)
      MODE_WAIT_SUPPLY: begin
        nxt_st.start_cnt = 6'h00;
        if (supply_in.controller_side_supply_ok && supply_in.high_side_supply_ok) begin
          nxt_st.mode = MODE_STARTUP;
        end
      end
      MODE_STARTUP: begin
        if (clk_rise) begin
          nxt_st.start_cnt = st_ff.start_cnt + 6'h01;
          if (st_ff.start_cnt == `STARTUP_PERIODS - 6'h01) begin
            nxt_st.mode = MODE_RUN;
          end
        end
      end
      MODE_RUN: begin
        nxt_st.mode = MODE_RUN;
      end
      default: begin
        nxt_st.mode = MODE_WAIT_SUPPLY;
      end
    endcase
    if (!supply_in.controller_side_supply_ok) begin
      nxt_st.mode = MODE_WAIT_SUPPLY;
    end

    if (clk_rise) begin
      // chopper period is 32 modulator clocks, so it flips every 16
      nxt_st.chop_cnt = st_ff.chop_cnt + 5'h01;
      if (st_ff.chop_cnt == 5'(`CHOP_DIVIDE / 6'd2 - 6'd1)) begin
        nxt_st.chop_cnt = 5'h00;
        nxt_st.chop     = ~st_ff.chop;
      end
      // one new bit per modulator clock, launched after its rising edge
      if (!supply_in.high_side_supply_ok) begin
        nxt_st.tx_bit = 1'b0;
      end else if (supply_in.common_mode_overvoltage) begin
        nxt_st.tx_bit = 1'b1;
      end else if (neg_clip || pos_clip) begin
        // integrators are cleared to zero so the loop does not wind up while clipped
        nxt_st.integ1   = 24'sh000000;
        nxt_st.integ2   = 24'sh000000;
        nxt_st.mark_cnt = st_ff.mark_cnt + 7'h01;
        // one counter serves both clip polarities
        nxt_st.tx_bit   = clip_bit(st_ff.mark_cnt, pos_clip);
      end else begin
        nxt_st.mark_cnt  = 7'h00;
        nxt_st.integ1    = sum1;
        nxt_st.integ2    = sum2;
        nxt_st.dac_level = decision;
        nxt_st.tx_bit    = decision;
      end
    end

    nxt_st.valid = (nxt_st.mode == MODE_RUN);
    if (!st_ff.valid) begin
      nxt_st.dout = 1'b0;
    end else if (MANCHESTER) begin
      // follows the clock level, so duty cycle tracks the supplied clock
      nxt_st.dout = st_ff.rx_bit ^ modulator_clock_in;
    end else begin
      nxt_st.dout = st_ff.rx_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff      <= '0;
      st_ff.mode <= MODE_WAIT_SUPPLY;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bitstream_out       = st_ff.dout;
  assign bitstream_valid_out = st_ff.valid;
  assign chopper_phase_out   = st_ff.chop;
  assign carrier_on_out      = st_ff.carrier;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // they watch the internal pipeline; the pin alone cannot tell a held bit
  // from a stuck one while the modulator clock is slow

  sequence seq_last_start;
    (st_ff.mode == MODE_STARTUP) && (st_ff.start_cnt == 6'd31) && clk_rise
      && supply_in.controller_side_supply_ok;
  endsequence

  sequence seq_keyed_one;
    st_ff.tx_bit ##1 st_ff.carrier;
  endsequence

  // a modulator rise in which the loop decides the bit
  sequence seq_loop_rise;
    clk_rise && loop_bit;
  endsequence

  // a modulator rise in which a clip level decides the bit
  sequence seq_clip_rise;
    clk_rise && clip_on;
  endsequence

  // a bit walks launch, carrier and recovery in turn
  sequence seq_bit_walk(b);
    (st_ff.tx_bit == b) ##1 (st_ff.carrier == b) ##1 (st_ff.rx_bit == b);
  endsequence

  chk_startup_valid: assert property (@(posedge clock_in) disable iff (rst_in)
    seq_last_start |=> st_ff.valid)
    else $error("output not valid after startup periods");

  chk_startup_early: assert property (@(posedge clock_in) disable iff (rst_in)
    $rose(st_ff.valid) |-> $past(st_ff.start_cnt) == 6'd31)
    else $error("output became valid too early");

  chk_failsafe_zero: assert property (@(posedge clock_in) disable iff (rst_in)
    (clk_rise && !supply_in.high_side_supply_ok) |=> !st_ff.tx_bit ##2 !st_ff.rx_bit)
    else $error("missing high side supply did not give zero");

  chk_overvolt_one: assert property (@(posedge clock_in) disable iff (rst_in)
    (clk_rise && supply_in.high_side_supply_ok && supply_in.common_mode_overvoltage)
      |=> st_ff.tx_bit)
    else $error("overvoltage did not give one");

  chk_clip_marker: assert property (@(posedge clock_in) disable iff (rst_in)
    (clk_rise && supply_in.high_side_supply_ok && !supply_in.common_mode_overvoltage
      && neg_clip) |=> st_ff.tx_bit == ($past(st_ff.mark_cnt) == 7'd127))
    else $error("negative clip marker wrong");

  chk_clip_pos: assert property (@(posedge clock_in) disable iff (rst_in)
    (clk_rise && supply_in.high_side_supply_ok && !supply_in.common_mode_overvoltage
      && pos_clip) |=> st_ff.tx_bit == ($past(st_ff.mark_cnt) != 7'd127))
    else $error("positive clip output wrong");

  chk_barrier_chain: assert property (@(posedge clock_in) disable iff (rst_in)
    seq_keyed_one |=> st_ff.rx_bit)
    else $error("carrier burst not recovered");

  chk_chop_rate: assert property (@(posedge clock_in) disable iff (rst_in)
    (st_ff.chop != $past(st_ff.chop)) |-> $past(clk_rise) && $past(st_ff.chop_cnt) == 5'd15)
    else $error("chopper toggled at wrong time");

  chk_dac_follow: assert property (@(posedge clock_in) disable iff (rst_in)
    (clk_rise && supply_in.high_side_supply_ok && !supply_in.common_mode_overvoltage
      && !neg_clip && !pos_clip) |=> st_ff.dac_level == st_ff.tx_bit)
    else $error("feedback level does not follow decision");

  chk_output_path: assert property (@(posedge clock_in) disable iff (rst_in)
    $past(st_ff.valid) |-> st_ff.dout ==
      ($past(st_ff.rx_bit) ^ (MANCHESTER & $past(modulator_clock_in))))
    else $error("output does not follow recovered bit");

  chk_valid_drop: assert property (@(posedge clock_in) disable iff (rst_in)
    !supply_in.controller_side_supply_ok |=> !st_ff.valid)
    else $error("valid held without controller side supply");

  chk_dout_quiet: assert property (@(posedge clock_in) disable iff (rst_in)
    !st_ff.valid |=> !st_ff.dout)
    else $error("output not low while invalid");

  chk_valid_mode: assert property (@(posedge clock_in) disable iff (rst_in)
    st_ff.valid |-> st_ff.mode == MODE_RUN)
    else $error("valid outside run mode");

  chk_mode_onehot: assert property (@(posedge clock_in) disable iff (rst_in)
    $onehot(st_ff.mode))
    else $error("mode code not one hot");

  chk_start_range: assert property (@(posedge clock_in) disable iff (rst_in)
    (st_ff.mode == MODE_STARTUP) |-> st_ff.start_cnt <= 6'd31)
    else $error("startup count overran");

  chk_wait_clear: assert property (@(posedge clock_in) disable iff (rst_in)
    (st_ff.mode == MODE_WAIT_SUPPLY) |=> st_ff.start_cnt == 6'h00)
    else $error("startup count not cleared while waiting");

  chk_run_stay: assert property (@(posedge clock_in) disable iff (rst_in)
    (st_ff.mode == MODE_RUN && supply_in.controller_side_supply_ok) |=> st_ff.mode == MODE_RUN)
    else $error("run mode left with supply present");

  chk_tx_stable: assert property (@(posedge clock_in) disable iff (rst_in)
    !clk_rise |=> $stable(st_ff.tx_bit) && $stable(st_ff.chop))
    else $error("bit or chopper moved without a clock rise");

  chk_chop_range: assert property (@(posedge clock_in) disable iff (rst_in)
    st_ff.chop_cnt <= 5'd15)
    else $error("chopper count overran");

  chk_chop_flip: assert property (@(posedge clock_in) disable iff (rst_in)
    (clk_rise && st_ff.chop_cnt == 5'd15) |=> st_ff.chop != $past(st_ff.chop))
    else $error("chopper missed its toggle");

  chk_carrier_follow: assert property (@(posedge clock_in) disable iff (rst_in)
    st_ff.carrier == $past(st_ff.tx_bit))
    else $error("carrier does not key the launched bit");

  chk_rx_follow: assert property (@(posedge clock_in) disable iff (rst_in)
    st_ff.rx_bit == $past(st_ff.carrier))
    else $error("receiver does not recover the carrier");

  chk_loop_bit: assert property (@(posedge clock_in) disable iff (rst_in)
    seq_loop_rise |=> st_ff.tx_bit == $past(decision))
    else $error("loop decision not launched");

  chk_marker_reset: assert property (@(posedge clock_in) disable iff (rst_in)
    seq_loop_rise |=> st_ff.mark_cnt == 7'h00)
    else $error("marker count not cleared outside clip");

  chk_marker_count: assert property (@(posedge clock_in) disable iff (rst_in)
    seq_clip_rise |=> st_ff.mark_cnt == $past(st_ff.mark_cnt) + 7'h01)
    else $error("marker count did not advance");

  chk_clip_hold: assert property (@(posedge clock_in) disable iff (rst_in)
    seq_clip_rise |=> (st_ff.integ1 == 24'sh000000)
      && (st_ff.integ2 == 24'sh000000))
    else $error("integrators not held while clipped");

  chk_zero_walk: assert property (@(posedge clock_in) disable iff (rst_in)
    (clk_rise && !supply_in.high_side_supply_ok) |=> seq_bit_walk(1'b0))
    else $error("failsafe zero not carried across");

  chk_overvolt_walk: assert property (@(posedge clock_in) disable iff (rst_in)
    (clk_rise && supply_in.high_side_supply_ok && supply_in.common_mode_overvoltage)
      |=> seq_bit_walk(1'b1))
    else $error("overvoltage one not carried across");

  chk_neg_marker: assert property (@(posedge clock_in) disable iff (rst_in)
    (clk_rise && clip_on && neg_clip && st_ff.mark_cnt == 7'd127)
      |=> seq_bit_walk(1'b1))
    else $error("negative marker one not carried across");

  chk_pos_marker: assert property (@(posedge clock_in) disable iff (rst_in)
    (clk_rise && clip_on && pos_clip && st_ff.mark_cnt == 7'd127)
      |=> seq_bit_walk(1'b0))
    else $error("positive marker zero not carried across");

endmodule : isolated_modulator_bitstream_out

`default_nettype wire
